// *** inc/ufb_defines.vh ***
// Constants for the fractional-baud serial port: register indexes, fields,
// reset values and timing counts. Assumes inclusion by bare name only.
`ifndef UFB_DEFINES_VH
`define UFB_DEFINES_VH

// Register indexes; the APB byte address is four times the index.
`define UFB_IDX_CONTROL   10'h098
`define UFB_IDX_DATA      10'h099
`define UFB_IDX_FRACTION  10'h09d
`define UFB_IDX_PRESCALE  10'h09e
`define UFB_IDX_CONFIG    10'h0a0

// Serial control register fields.
`define UFB_CTL_MODE_HI   7
`define UFB_CTL_MODE_LO   6
`define UFB_CTL_FCHK      5
`define UFB_CTL_RXEN      4
`define UFB_CTL_TXB8      3
`define UFB_CTL_RXB8      2
`define UFB_CTL_TXF       1
`define UFB_CTL_RXF       0

// Fraction register fields.
`define UFB_FRAC_EN       7
`define UFB_FRAC_MSB      5

// Prescale register fields.
`define UFB_PRE_OWE       7
`define UFB_PRE_FE        6
`define UFB_PRE_EXT_MSB   4
`define UFB_PRE_EXT_LSB   3
`define UFB_PRE_DIV_MSB   2

// Own configuration register fields.
`define UFB_CFG_EXTENDED_SERIAL_ENABLE     0
`define UFB_CFG_CD_LSB    1
`define UFB_CFG_CD_MSB    3
`define UFB_CFG_RDBL      4
`define UFB_CFG_T2TX      5
`define UFB_CFG_T2RX      6

// Reset values.
`define UFB_RST_BYTE      8'h00

// Mode 0 shift clock: core clock divided by twelve, low for the first half.
`define UFB_M0_DIV        4'd12
`define UFB_M0_HALF       4'd6
`define UFB_BITS          4'd8
`define UFB_OVERSAMPLE    5'd16
`define UFB_MID_SAMPLE    4'd7
`define UFB_FRAC_ONE      7'd64

`endif

// *** design/ufb_baud.v ***
// Baud tick generator: sixteen-times-bit-rate ticks for transmit and receive.
// Assumes timer overflow inputs are one-cycle pulses synchronous to mclk.
`timescale 1ns/1ps
`include "ufb_defines.vh"

module ufb_baud #(
  parameter ACC_W = 25
) (
  // Clock and reset.
  input  wire       mclk,
  input  wire       rst_b,
  // Configuration.
  input  wire       frac_baud_gen_enable,
  input  wire [5:0] baud_fraction_value,
  input  wire [2:0] baud_div,
  input  wire [1:0] prescale_extension,
  input  wire [2:0] core_clock_divide,
  input  wire       rate_double,
  input  wire       timer_two_tx_clock_sel,
  input  wire       timer_two_rx_clock_sel,
  // Legacy timer overflows.
  input  wire       timer1_ovf,
  input  wire       timer2_ovf,
  // Ticks.
  output wire       tx_tick,
  output wire       rx_tick
);

  reg  [ACC_W-1:0] acc;
  reg              frac_tick;
  reg              t1_half;
  wire [4:0]       shift_exp;
  wire [ACC_W-1:0] limit;
  wire [ACC_W-1:0] acc_step;
  wire             t1_tick;

  // Tick period is 2^(cd+ext+div) * (1 + frac/64) clocks, kept exact on
  // average by counting in sixty-fourths of a clock.
  assign shift_exp = {2'b00, core_clock_divide} + {3'b000, prescale_extension}
                   + {2'b00, baud_div};
  assign limit     = {{(ACC_W-7){1'b0}}, `UFB_FRAC_ONE + {1'b0, baud_fraction_value}}
                   << shift_exp;
  assign acc_step  = acc + {{(ACC_W-7){1'b0}}, `UFB_FRAC_ONE};

  // Fractional accumulator; held clear while the dedicated timer is off.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc       <= {ACC_W{1'b0}};
      frac_tick <= 1'b0;
    end else if (!frac_baud_gen_enable) begin
      acc       <= {ACC_W{1'b0}};
      frac_tick <= 1'b0;
    end else if (acc_step >= limit) begin
      acc       <= acc_step - limit;
      frac_tick <= 1'b1;
    end else begin
      acc       <= acc_step;
      frac_tick <= 1'b0;
    end
  end

  // Timer 1 path halves the overflow rate unless rate doubling is set.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      t1_half <= 1'b0;
    end else if (timer1_ovf) begin
      t1_half <= ~t1_half;
    end
  end
  assign t1_tick = timer1_ovf & (rate_double | t1_half);

  // The dedicated timer overrides rate doubling and the timer 2 selects.
  assign tx_tick = frac_baud_gen_enable ? frac_tick :
                   (timer_two_tx_clock_sel ? timer2_ovf : t1_tick);
  assign rx_tick = frac_baud_gen_enable ? frac_tick :
                   (timer_two_rx_clock_sel ? timer2_ovf : t1_tick);

endmodule

// *** design/ufb_uart.v ***
// Serial port with fractional baud timer, shift-register mode 0 and 8-bit
// asynchronous mode 1, registers on an APB slave. Assumes synchronous pins.
`timescale 1ns/1ps
`include "ufb_defines.vh"

module ufb_uart #(
  parameter ADDR_W = 12
) (
  // Clock and reset.
  input  wire              mclk,
  input  wire              rst_b,
  // APB slave.
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  // Legacy baud timer overflows.
  input  wire              timer1_ovf,
  input  wire              timer2_ovf,
  // Serial pins; rx pin is two-way in mode 0.
  input  wire              rxd_in,
  output reg               rxd_out,
  output reg               rxd_oe,
  output reg               txd
);

  localparam TX_IDLE  = 2'd0;
  localparam TX_M0    = 2'd1;
  localparam TX_M1    = 2'd2;
  localparam RX_IDLE  = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA  = 2'd2;

  // Software-visible state.
  reg [7:0] serial_control_reg;
  reg [7:0] serial_data_buffer;
  reg       frac_baud_gen_enable;
  reg [5:0] baud_fraction_value;
  reg [4:0] baud_prescale_control;
  reg       overwrite_error;
  reg       frame_error;
  reg [6:0] config_reg;

  // Transmit / mode 0 engine.
  reg [1:0] tx_state;
  reg [8:0] tx_shift;
  reg [3:0] tx_bit;
  reg [3:0] tx_sub;
  reg [3:0] m0_phase;
  reg       m0_rx;

  // Mode 1 receiver.
  reg [1:0] rx_state;
  reg [8:0] rx_shift;
  reg [3:0] rx_bit;
  reg [3:0] rx_sub;
  reg       rxd_prev;

  // Hardware flag events, one cycle each.
  reg       set_ri;
  reg       set_ti;
  reg       set_rb8;
  reg       rb8_val;
  reg       set_owe;
  reg       fe_upd;
  reg       fe_val;
  reg       buf_load;
  reg [7:0] buf_val;

  wire       tx_tick;
  wire       rx_tick;
  wire [9:0] idx = paddr[ADDR_W-1:2];
  wire       wr = psel & penable & pwrite;
  wire       rd = psel & ~pwrite;
  wire       hit_ctl = (idx == `UFB_IDX_CONTROL);
  wire       hit_dat = (idx == `UFB_IDX_DATA);
  wire       hit_frac = (idx == `UFB_IDX_FRACTION);
  wire       hit_pre = (idx == `UFB_IDX_PRESCALE);
  wire       hit_cfg = (idx == `UFB_IDX_CONFIG);
  wire       mapped = hit_ctl | hit_dat | hit_frac | hit_pre | hit_cfg;
  wire       mode_hi = serial_control_reg[`UFB_CTL_MODE_HI];
  wire       mode_lo = serial_control_reg[`UFB_CTL_MODE_LO];
  wire       mode0 = ~mode_hi & ~mode_lo;
  wire       mode1 = ~mode_hi & mode_lo;
  wire       ri = serial_control_reg[`UFB_CTL_RXF];
  wire       rx_en = serial_control_reg[`UFB_CTL_RXEN];
  wire       ext_en = config_reg[`UFB_CFG_EXTENDED_SERIAL_ENABLE];
  wire       data_wr = wr & hit_dat;

  // The slave answers in the access cycle; unmapped addresses flag an error.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  ufb_baud u_baud (
    .mclk                   (mclk),
    .rst_b                  (rst_b),
    .frac_baud_gen_enable   (frac_baud_gen_enable),
    .baud_fraction_value    (baud_fraction_value),
    .baud_div               (baud_prescale_control[2:0]),
    .prescale_extension     (baud_prescale_control[4:3]),
    .core_clock_divide      (config_reg[`UFB_CFG_CD_MSB:`UFB_CFG_CD_LSB]),
    .rate_double            (config_reg[`UFB_CFG_RDBL]),
    .timer_two_tx_clock_sel (config_reg[`UFB_CFG_T2TX]),
    .timer_two_rx_clock_sel (config_reg[`UFB_CFG_T2RX]),
    .timer1_ovf             (timer1_ovf),
    .timer2_ovf             (timer2_ovf),
    .tx_tick                (tx_tick),
    .rx_tick                (rx_tick)
  );

  // Read data is registered in the setup cycle so it stands in the access.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd & ~penable) begin
      prdata <= 32'h0000_0000;
      if (hit_ctl) prdata[7:0] <= serial_control_reg;
      if (hit_dat) prdata[7:0] <= serial_data_buffer;
      if (hit_frac) prdata[7:0] <= {frac_baud_gen_enable, 1'b0, baud_fraction_value};
      if (hit_pre) prdata[7:0] <= {overwrite_error, frame_error, 1'b0,
                                   baud_prescale_control};
      if (hit_cfg) prdata[6:0] <= config_reg;
    end
  end

  // Configuration registers written by software.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frac_baud_gen_enable  <= 1'b0;
      baud_fraction_value   <= 6'h00;
      baud_prescale_control <= 5'h00;
      config_reg            <= 7'h00;
    end else if (wr) begin
      if (hit_frac) begin
        frac_baud_gen_enable <= pwdata[`UFB_FRAC_EN];
        baud_fraction_value  <= pwdata[`UFB_FRAC_MSB:0];
      end
      if (hit_pre) baud_prescale_control <= pwdata[`UFB_PRE_EXT_MSB:0];
      if (hit_cfg) config_reg <= pwdata[6:0];
    end
  end

  // Control register: hardware sets win over a software write that clears.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      serial_control_reg <= `UFB_RST_BYTE;
    end else begin
      if (wr & hit_ctl) begin
        serial_control_reg <= pwdata[7:0];
      end
      if (set_ri) serial_control_reg[`UFB_CTL_RXF] <= 1'b1;
      if (set_ti) serial_control_reg[`UFB_CTL_TXF] <= 1'b1;
      if (set_rb8) serial_control_reg[`UFB_CTL_RXB8] <= rb8_val;
    end
  end

  // Data buffer and error flags; overwrite error clears only by writing 0.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      serial_data_buffer <= `UFB_RST_BYTE;
      overwrite_error    <= 1'b0;
      frame_error        <= 1'b0;
    end else begin
      if (buf_load) serial_data_buffer <= buf_val;
      if (set_owe) begin
        overwrite_error <= 1'b1;
      end else if (wr & hit_pre & ~pwdata[`UFB_PRE_OWE]) begin
        overwrite_error <= 1'b0;
      end
      if (fe_upd) frame_error <= fe_val;
    end
  end

  // Transmitter and mode 0 engine. Mode 0 reception shares the shift clock,
  // so a data write during a mode 0 receive is ignored rather than mixed in.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= TX_IDLE;
      tx_shift <= 9'h000;
      tx_bit   <= 4'h0;
      tx_sub   <= 4'h0;
      m0_phase <= 4'h0;
      m0_rx    <= 1'b0;
      txd      <= 1'b1;
      rxd_out  <= 1'b1;
      rxd_oe   <= 1'b0;
      set_ti   <= 1'b0;
    end else begin
      set_ti <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          txd    <= 1'b1;
          rxd_oe <= 1'b0;
          tx_bit <= 4'h0;
          tx_sub <= 4'h0;
          m0_phase <= 4'h0;
          if (data_wr & mode0) begin
            tx_shift <= {1'b1, pwdata[7:0]};
            m0_rx    <= 1'b0;
            tx_state <= TX_M0;
          end else if (data_wr & mode1) begin
            tx_shift <= {1'b1, pwdata[7:0]};
            tx_state <= TX_M1;
          end else if (mode0 & rx_en & ~ri & ~set_ri) begin
            // A finished receive whose flag is not yet set must not start another.
            m0_rx    <= 1'b1;
            tx_state <= TX_M0;
          end
        end
        TX_M0: begin
          // Shift clock low for six cycles, high for six.
          txd     <= (m0_phase >= `UFB_M0_HALF);
          rxd_oe  <= ~m0_rx;
          rxd_out <= tx_shift[0];
          if (m0_phase == `UFB_M0_DIV - 4'd1) begin
            m0_phase <= 4'h0;
            tx_bit   <= tx_bit + 4'd1;
            tx_shift <= m0_rx ? {1'b1, rxd_in, tx_shift[7:1]}
                              : {1'b1, tx_shift[8:1]};
            if (tx_bit == `UFB_BITS - 4'd1) begin
              tx_state <= TX_IDLE;
              set_ti   <= ~m0_rx;
            end
          end else begin
            m0_phase <= m0_phase + 4'd1;
          end
        end
        TX_M1: begin
          rxd_oe <= 1'b0;
          txd    <= (tx_bit == 4'h0) ? 1'b0 : tx_shift[0];
          if (tx_tick) begin
            tx_sub <= tx_sub + 4'd1;
            if (tx_sub == `UFB_OVERSAMPLE - 5'd1) begin
              tx_bit <= tx_bit + 4'd1;
              if (tx_bit != 4'h0) tx_shift <= {1'b1, tx_shift[8:1]};
              if (tx_bit == `UFB_BITS) set_ti <= 1'b1;
              if (tx_bit == `UFB_BITS + 4'd1) tx_state <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
      if (~mode0 & ~mode1) tx_state <= TX_IDLE;
    end
  end

  // Mode 1 receiver at sixteen ticks per bit, sampled mid-bit.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= RX_IDLE;
      rx_shift <= 9'h000;
      rx_bit   <= 4'h0;
      rx_sub   <= 4'h0;
      rxd_prev <= 1'b1;
    end else begin
      rxd_prev <= rxd_in;
      case (rx_state)
        RX_IDLE: begin
          rx_sub <= 4'h0;
          rx_bit <= 4'h0;
          if (mode1 & rx_en & rxd_prev & ~rxd_in) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_sub <= rx_sub + 4'd1;
            if (rx_sub == `UFB_MID_SAMPLE) begin
              rx_sub <= 4'h0;
              rx_state <= rxd_in ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_sub <= rx_sub + 4'd1;
            if (rx_sub == `UFB_OVERSAMPLE - 5'd1) begin
              rx_shift <= {rxd_in, rx_shift[8:1]};
              rx_bit   <= rx_bit + 4'd1;
              if (rx_bit == `UFB_BITS) rx_state <= RX_IDLE;
            end
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
      if (~mode1) rx_state <= RX_IDLE;
    end
  end

  // Final shift pulse decisions and the mode 0 receive completion.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      set_ri   <= 1'b0;
      set_rb8  <= 1'b0;
      rb8_val  <= 1'b0;
      set_owe  <= 1'b0;
      fe_upd   <= 1'b0;
      fe_val   <= 1'b0;
      buf_load <= 1'b0;
      buf_val  <= 8'h00;
    end else begin
      set_ri   <= 1'b0;
      set_rb8  <= 1'b0;
      set_owe  <= 1'b0;
      fe_upd   <= 1'b0;
      buf_load <= 1'b0;
      if (rx_state == RX_DATA && rx_tick && rx_sub == `UFB_OVERSAMPLE - 5'd1 &&
          rx_bit == `UFB_BITS) begin
        fe_upd  <= 1'b1;
        fe_val  <= ~rxd_in;
        set_owe <= ri;
        // Accept only if the buffer is free (or extended) and, with frame check on, the stop is one.
        if ((ext_en | ~ri) & (~serial_control_reg[`UFB_CTL_FCHK] | rxd_in)) begin
          buf_load <= 1'b1;
          buf_val  <= rx_shift[8:1];
          set_rb8  <= 1'b1;
          rb8_val  <= rxd_in;
          set_ri   <= 1'b1;
        end
      end else if (tx_state == TX_M0 && m0_rx && tx_bit == `UFB_BITS - 4'd1 &&
                   m0_phase == `UFB_M0_DIV - 4'd1) begin
        buf_load <= 1'b1;
        buf_val  <= {rxd_in, tx_shift[7:1]};
        set_ri   <= 1'b1;
      end
    end
  end

endmodule

// *** dv/ufb_uart_sva.sv ***
// Checker for the serial port's APB and pin behaviour.
// Assumes a bind to ufb_uart and the single mclk domain.
`timescale 1ns/1ps
`include "ufb_defines.vh"

module ufb_uart_sva #(
  parameter ADDR_W = 12
) (
  // Clock and reset.
  input wire              mclk,
  input wire              rst_b,
  // APB slave.
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       pwdata,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  // Serial pins.
  input wire              rxd_in,
  input wire              rxd_out,
  input wire              rxd_oe,
  input wire              txd
);
  localparam [ADDR_W-1:0] A_FRA = {`UFB_IDX_FRACTION, 2'b00};
  reg [7:0] frac_w;
  reg       txd_q;
  reg [3:0] falls;
  wire      rd_frac = psel && !penable && !pwrite && (paddr == A_FRA);

  // Shadow of the fraction register and a count of shift clock falls while driving.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frac_w <= 8'h00;
      txd_q  <= 1'b1;
      falls  <= 4'h0;
    end else begin
      txd_q <= txd;
      if (psel && penable && pwrite && (paddr == A_FRA))
        frac_w <= pwdata[7:0];
      if (!rxd_oe)
        falls <= 4'h0;
      else if (txd_q && !txd)
        falls <= falls + 4'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_frac_gap; rd_frac |=> prdata[6] == 1'b0; endproperty
  a_frac_gap: assert property (p_frac_gap) else $error("fraction bit six reads one");
  property p_frac_val; rd_frac |=> prdata[7:0] == {frac_w[7], 1'b0, frac_w[5:0]}; endproperty
  a_frac_val: assert property (p_frac_val) else $error("fraction read-back wrong");
  property p_m0_lo; $fell(txd) && rxd_oe |-> !txd [*6] ##1 txd; endproperty
  a_m0_lo: assert property (p_m0_lo) else $error("shift clock low phase wrong");
  property p_m0_hi; $rose(txd) && rxd_oe |-> txd [*6]; endproperty
  a_m0_hi: assert property (p_m0_hi) else $error("shift clock high phase short");
  property p_m0_cnt; $fell(rxd_oe) |-> falls == 4'h8; endproperty
  a_m0_cnt: assert property (p_m0_cnt) else $error("shift transfer not eight bits");
  property p_m0_shift; rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> $fell(txd); endproperty
  a_m0_shift: assert property (p_m0_shift) else $error("data changed mid bit");
  property p_m0_clk; $rose(rxd_oe) |-> ##[0:1] !txd; endproperty
  a_m0_clk: assert property (p_m0_clk) else $error("no shift clock on tx pin");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("slave error outside access");

  c_m0: cover property ($rose(rxd_oe));
  c_frac: cover property (rd_frac);
  c_err: cover property (pslverr);
endmodule

bind ufb_uart ufb_uart_sva #(.ADDR_W(ADDR_W)) u_sva (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));

// *** dv/ufb_peer.sv ***
// Far-side model: a remote asynchronous device and an external shift register.
// Assumes the bench sets the mode and the bit length in mclk cycles.
`timescale 1ns/1ps

module ufb_peer (
  // Clock.
  input wire        mclk,
  // Device pins.
  input wire        txd,
  input wire        rxd_oe,
  input wire        rxd_out,
  // Bench settings.
  input wire        mode0,
  input wire  [7:0] bit_cyc,
  // Line towards the device.
  output logic      line
);
  logic [7:0] got;
  logic [8:0] fr;
  logic       got_stop;
  logic [7:0] src;
  int         got_n;
  int         idx;

  initial begin
    line  = 1'b1;
    got_n = 0;
    idx   = 8;
  end

  // Frame monitor: skips the start bit, then samples eight data bits and stop at mid-bit.
  initial forever begin
    @(negedge txd);
    if (!mode0) begin
      repeat (bit_cyc / 2) @(posedge mclk);
      repeat (9) begin
        repeat (bit_cyc) @(posedge mclk);
        fr = {txd, fr[8:1]};
      end
      got      = fr[7:0];
      got_stop = fr[8];
      got_n++;
    end
  end

  // Shift register captures on the rising shift clock, where data is settled.
  initial forever begin
    @(posedge txd);
    if (mode0 && rxd_oe) begin
      got = {rxd_out, got[7:1]};
      got_n++;
    end
  end

  // Shift register source; once emptied it no longer holds its last bit.
  initial forever begin
    @(negedge txd);
    if (mode0 && !rxd_oe) begin
      line <= (idx < 8) ? src[idx] : ~line;
      idx++;
    end
  end

  task load0(input logic [7:0] b);
    src = b;
    idx = 0;
  endtask

  // Sends one frame; the stop value is free so that framing faults can be made.
  task send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    repeat (10) begin
      @(posedge mclk);
      line <= f[0];
      f = f >> 1;
      repeat (bit_cyc - 1) @(posedge mclk);
    end
    @(posedge mclk);
    line <= 1'b1;
  endtask

  // A short low pulse, then quiet long enough for the receiver to give up.
  task glitch;
    @(posedge mclk);
    line <= 1'b0;
    repeat (3) @(posedge mclk);
    line <= 1'b1;
    repeat (16) @(posedge mclk);
  endtask
endmodule

// *** dv/ufb_uart_tb.sv ***
// Self-checking bench for the serial port: APB registers, mode 1 and mode 0.
// Assumes the checker is bound and the far-side model is ufb_peer.
`timescale 1ns/1ps
`include "ufb_defines.vh"

module ufb_uart_tb;
  localparam [11:0] A_CTL = {`UFB_IDX_CONTROL, 2'b00};
  localparam [11:0] A_DAT = {`UFB_IDX_DATA, 2'b00};
  localparam [11:0] A_FRA = {`UFB_IDX_FRACTION, 2'b00};
  localparam [11:0] A_PRE = {`UFB_IDX_PRESCALE, 2'b00};
  localparam [11:0] A_CFG = {`UFB_IDX_CONFIG, 2'b00};
  logic [7:0]  fra_t [5] = '{8'h80, 8'h80, 8'h80, 8'ha0, 8'h00};
  logic [7:0]  pre_t [5] = '{8'h00, 8'h01, 8'h08, 8'h00, 8'h00};
  logic [7:0]  cfg_t [5] = '{8'h00, 8'h02, 8'h00, 8'h70, 8'h60};
  logic        mclk, rst_b, psel, penable, pwrite, timer1_ovf, timer2_ovf, mode0, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [7:0]  bit_cyc, b, b1;
  wire  [31:0] prdata;
  wire         pready, pslverr, rxd_out, rxd_oe, txd, peer_line;
  wire         rxd_in = rxd_oe ? rxd_out : peer_line;
  int          failures, compares, cycles, seed, k, n;

  ufb_uart #(.ADDR_W(12)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
  ufb_peer u_peer (.mclk(mclk), .txd(txd), .rxd_oe(rxd_oe), .rxd_out(rxd_out),
    .mode0(mode0), .bit_cyc(bit_cyc), .line(peer_line));

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // Timer 2 overflows every other cycle so its bit time is known; timer 1 is noise.
  always @(posedge mclk) begin
    timer2_ovf <= ~timer2_ovf;
    timer1_ovf <= ($random(seed) % 5) == 0;
    cycles++;
    if (cycles == 60000) begin
      failures++;
      finish_test;
    end
  end

  function automatic logic [31:0] frac_rd(input logic [7:0] v);
    return {24'h0, v[7], 1'b0, v[5:0]};
  endfunction

  // Bit time: sixteen ticks scaled by core divide, prescale and fraction, or 32 clocks with the fraction off.
  function automatic logic [7:0] bit_len(input logic [7:0] f, input logic [7:0] p,
                                         input logic [7:0] c);
    if (!f[7])
      return 8'd32;
    return 8'((16 << ({2'b00, p[2:0]} + p[4:3] + c[3:1])) * (64 + f[5:0]) / 64);
  endfunction

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task finish_test;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_bit(input int pos);
    n = 0;
    apb(1'b0, A_CTL, 8'h00, q);
    while (q[pos] !== 1'b1 && n < 400) begin
      apb(1'b0, A_CTL, 8'h00, q);
      n++;
    end
  endtask

  initial begin
    {psel, penable, pwrite, timer1_ovf, timer2_ovf, mode0, rst_b} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    bit_cyc = 8'd16;
    seed = 29;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    // Reset value, an unmapped place, then random fraction read-back.
    apb(1'b0, A_FRA, 8'h00, q);
    chk("fraction reset", q, 32'h0);
    apb(1'b0, 12'hffc, 8'h00, q);
    chk("unmapped error", 32'(err), 32'h1);
    repeat (4) begin
      b = 8'($random(seed));
      apb(1'b1, A_FRA, b, q);
      apb(1'b0, A_FRA, 8'h00, q);
      chk("fraction", q, frac_rd(b));
    end
    // Transmit over rates: prescale, extension, fraction, ignored selects, timer 2.
    for (k = 0; k < 5; k++) begin
      apb(1'b1, A_FRA, fra_t[k], q);
      apb(1'b1, A_PRE, pre_t[k], q);
      apb(1'b1, A_CFG, cfg_t[k], q);
      apb(1'b1, A_CTL, 8'h50, q);
      bit_cyc = bit_len(fra_t[k], pre_t[k], cfg_t[k]);
      b = 8'($random(seed));
      n = u_peer.got_n;
      apb(1'b1, A_DAT, b, q);
      for (int m = 0; m < 2000 && u_peer.got_n == n; m++) @(posedge mclk);
      chk("tx byte", 32'(u_peer.got), 32'(b));
      chk("tx stop", 32'(u_peer.got_stop), 32'h1);
      apb(1'b0, A_CTL, 8'h00, q);
      chk("transmit flag", 32'(q[1]), 32'h1);
      // Let the stop bit finish before the next rate is written.
      repeat (bit_cyc) @(posedge mclk);
    end
    apb(1'b1, A_FRA, 8'h80, q);
    apb(1'b1, A_CFG, 8'h00, q);
    bit_cyc = 8'd16;
    // Reception, then a second frame while the flag is still set.
    b = 8'($random(seed));
    b1 = ~b;
    u_peer.send(b, 1'b1);
    apb(1'b0, A_CTL, 8'h00, q);
    chk("rx flags", 32'({q[2], q[0]}), 32'h3);
    apb(1'b0, A_DAT, 8'h00, q);
    chk("rx data", q, 32'(b));
    u_peer.send(b1, 1'b1);
    apb(1'b0, A_DAT, 8'h00, q);
    chk("kept data", q, 32'(b));
    apb(1'b0, A_PRE, 8'h00, q);
    chk("overwrite", 32'(q[7]), 32'h1);
    apb(1'b1, A_PRE, 8'h00, q);
    apb(1'b0, A_PRE, 8'h00, q);
    chk("overwrite clear", 32'(q[7]), 32'h0);
    // Extended mode accepts a frame although the receive flag is still set.
    apb(1'b1, A_CFG, 8'h01, q);
    u_peer.send(b1, 1'b1);
    apb(1'b0, A_DAT, 8'h00, q);
    chk("extended data", q, 32'(b1));
    // Frame check on: a glitch and a frame with a zero stop bit are both dropped.
    apb(1'b1, A_CTL, 8'h70, q);
    u_peer.glitch;
    u_peer.send(b1, 1'b0);
    apb(1'b0, A_CTL, 8'h00, q);
    chk("bad frame flag", 32'(q[0]), 32'h0);
    apb(1'b0, A_PRE, 8'h00, q);
    chk("frame error", 32'(q[6]), 32'h1);
    // Shift register mode: transmit, then receive.
    apb(1'b1, A_CTL, 8'h00, q);
    mode0 <= 1'b1;
    b = 8'($random(seed));
    u_peer.got_n = 0;
    apb(1'b1, A_DAT, b, q);
    wait_bit(1);
    chk("m0 bits", 32'(u_peer.got_n), 32'h8);
    chk("m0 byte", 32'(u_peer.got), 32'(b));
    b = 8'($random(seed));
    u_peer.load0(b);
    apb(1'b1, A_CTL, 8'h10, q);
    wait_bit(0);
    apb(1'b0, A_DAT, 8'h00, q);
    chk("m0 rx", q, 32'(b));
    // With the flag set no further reception may overwrite the buffer.
    repeat (120) @(posedge mclk);
    apb(1'b0, A_DAT, 8'h00, q);
    chk("m0 no restart", q, 32'(b));
    finish_test;
  end
endmodule
